// ==== verilog/txa_decoder.sv ====
// Purpose: decodes transmit command A and trims each buffer's data
// Assumes: host write port and register port share clk_in
// Notes: data leaves as whole words with a byte-valid mask
//
// Overview of operation
// [R01] completion request bit sets buffer done once whole buffer is loaded
// [R02] buffer done flag reaches the interrupt output when software enables it
// [R03] alignment code selects 4, 16 or 32 byte end alignment; 11 reserved
// [R04] host pads each buffer with words up to the selected alignment
// [R05] padding words are dropped and never reach the frame
// [R06] start offset 0 to 31 bytes; byte at offset is first data byte
// [R07] host writes zero into all reserved command fields
// [R08] bit 13 marks first segment, bit 12 last segment of a packet
// [R09] byte counts summed over a packet; mismatch with length sets error
// [R10] low offset bits choose first byte lane; upper bits skip words
// [R11] start offset is taken from bits 20:16 of command A
`timescale 1ns/1ps
module txa_decoder
  import txa_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic half_wr_in,
  input wire logic [15:0] half_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic data_valid_out,
  output logic [31:0] data_out,
  output logic [3:0] data_be_out,
  output logic data_first_out,
  output logic data_last_out,
  output logic irq_out
);
  logic word_valid;
  logic [31:0] word;
  txa_state_t state;
  logic [31:0] cmd_a;
  logic [31:0] cmd_b;
  logic [31:0] ref_b;
  logic [9:0] widx;
  logic [11:0] total;
  logic in_pkt;
  logic sop_pend;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] enable;
  logic [ST_W-1:0] next_set;
  logic [ST_W-1:0] clr;

  txa_half_pair u_pair (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .half_wr_in(half_wr_in),
    .half_in(half_in),
    .word_valid_out(word_valid),
    .word_out(word)
  );

  // decoded fields of the current command A
  logic [4:0] off;
  logic [10:0] size;
  logic [1:0] align;
  logic [11:0] span;
  logic [9:0] data_words;
  logic [9:0] amask;
  logic [9:0] pad_words;
  logic [11:0] next_total;
  logic [3:0] lane_ok;

  assign off = cmd_a[OFF_HI:OFF_LO]; // [R11]
  assign size = cmd_a[SIZE_HI:0]; // [R09]
  assign align = cmd_a[ALIGN_HI:ALIGN_LO];
  assign span = {7'h00, off} + {1'b0, size};
  assign data_words = 10'((span + 12'h003) >> 2);

  always_comb
  begin
    case (align) // [R03]
      ALIGN_16: amask = MASK_16;
      ALIGN_32: amask = MASK_32;
      default: amask = MASK_4; // reserved code falls back to 4-byte
    endcase
  end

  assign pad_words = (data_words + amask) & ~amask;
  assign next_total = cmd_a[FIRST_SEG_BIT] ? {1'b0, size} :
                      total + {1'b0, size};

  // byte lane is live when its buffer index lies in [off, off+size)
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      logic [11:0] bidx;
      assign bidx = {widx, 2'(g)};
      assign lane_ok[g] = (bidx >= {7'h00, off}) &&
                          (bidx < span); // [R06] [R10]
    end
  endgenerate

  logic take_a;
  logic take_b;
  logic take_d;
  logic end_buf;
  logic in_data;
  assign take_a = word_valid && (state == TXA_CMDA);
  assign take_b = word_valid && (state == TXA_CMDB);
  assign take_d = word_valid && (state == TXA_DATA);
  assign in_data = widx < data_words;
  // an empty padded buffer ends right at command B
  assign end_buf = (take_d && (widx == pad_words - 10'h001)) ||
                   (take_b && (pad_words == 10'h000)); // [R01]

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= TXA_CMDA;
      cmd_a <= 32'h0000_0000;
      cmd_b <= 32'h0000_0000;
      widx <= 10'h000;
    end
    else
    begin
      if (take_a)
      begin
        cmd_a <= word; // [R11]
        state <= TXA_CMDB;
      end
      if (take_b)
      begin
        cmd_b <= word;
        widx <= 10'h000;
        state <= (pad_words == 10'h000) ? TXA_CMDA : TXA_DATA;
      end
      if (take_d)
      begin
        widx <= widx + 10'h001;
        if (end_buf)
          state <= TXA_CMDA;
      end
    end
  end

  // packet accounting across segments
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      total <= 12'h000;
      ref_b <= 32'h0000_0000;
      in_pkt <= 1'b0;
      sop_pend <= 1'b0;
    end
    else
    begin
      if (take_b)
      begin
        total <= next_total; // [R09]
        if (cmd_a[FIRST_SEG_BIT])
          ref_b <= word;
        in_pkt <= !cmd_a[LS_BIT]; // [R08]
      end
      if (take_b && cmd_a[FIRST_SEG_BIT])
        sop_pend <= 1'b1; // [R08]
      else if (take_d && (lane_ok != 4'h0))
        sop_pend <= 1'b0;
    end
  end

  // events: done at buffer end if requested, error on packet inconsistency or reserved alignment
  always_comb
  begin
    next_set = '0;
    next_set[ST_DONE] = end_buf && cmd_a[IOC_BIT]; // [R01]
    next_set[ST_ERR] = take_b && (
      (cmd_a[LS_BIT] && (next_total != {1'b0, word[LEN_HI:0]})) ||
      (!cmd_a[FIRST_SEG_BIT] && (word != ref_b)) ||
      (cmd_a[FIRST_SEG_BIT] == in_pkt) ||
      (align == ALIGN_RSV)); // [R09]
  end

  // padding and pre-offset words leave no output
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      data_valid_out <= 1'b0;
      data_out <= 32'h0000_0000;
      data_be_out <= 4'h0;
      data_first_out <= 1'b0;
      data_last_out <= 1'b0;
    end
    else
    begin
      data_valid_out <= take_d && in_data && (lane_ok != 4'h0); // [R05]
      data_out <= word;
      data_be_out <= lane_ok; // [R10]
      data_first_out <= sop_pend;
      data_last_out <= cmd_a[LS_BIT] && (widx == data_words - 10'h001);
    end
  end

  // register port; set wins over a simultaneous clear
  assign clr = (reg_wr_in && (reg_addr_in == REG_CLEAR)) ?
               reg_wdata_in[ST_W-1:0] : '0;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      status <= '0;
      enable <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      status <= (status & ~clr) | next_set;
      if (reg_wr_in && (reg_addr_in == REG_ENABLE))
        enable <= reg_wdata_in[ST_W-1:0];
      irq_out <= |(status & enable); // [R02]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= 32'h0000_0000;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        REG_STATUS: reg_rdata_out <= {{(32-ST_W){1'b0}}, status};
        REG_ENABLE: reg_rdata_out <= {{(32-ST_W){1'b0}}, enable};
        REG_CMDA: reg_rdata_out <= cmd_a;
        REG_TOTAL: reg_rdata_out <= {20'h00000, total};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_out <= 32'h0000_0000;
  end

  // checks
  sequence s_last_pad;
    take_d && (widx == pad_words - 10'h001) && cmd_a[IOC_BIT];
  endsequence

  sequence s_cmdb_first;
    take_b && cmd_a[FIRST_SEG_BIT];
  endsequence

  property p_done_set;
    @(posedge clk_in) disable iff (!nrst_in)
    s_last_pad |=> status[ST_DONE] ##1
      (status[ST_DONE] || $past(clr[ST_DONE]));
  endproperty
  a_done_set: assert property (p_done_set) // [R01]
    else $error("buffer done not raised at buffer end");

  property p_irq_route;
    @(posedge clk_in) disable iff (!nrst_in)
    ##1 (irq_out == $past(|(status & enable)));
  endproperty
  a_irq_route: assert property (p_irq_route) // [R02]
    else $error("interrupt output does not follow enabled status");

  property p_align;
    @(posedge clk_in) disable iff (!nrst_in)
    take_d && end_buf && (align == ALIGN_32) |-> widx[2:0] == 3'h7;
  endproperty
  a_align: assert property (p_align) // [R03]
    else $error("32-byte alignment not kept");

  property p_pad_drop;
    @(posedge clk_in) disable iff (!nrst_in)
    take_d && !in_data |=> !data_valid_out;
  endproperty
  a_pad_drop: assert property (p_pad_drop) // [R05]
    else $error("padding word reached output");

  property p_skip_words;
    @(posedge clk_in) disable iff (!nrst_in)
    take_d && (widx < {7'h00, off[4:2]}) |=> !data_valid_out;
  endproperty
  a_skip_words: assert property (p_skip_words) // [R06]
    else $error("word before start offset was emitted");

  property p_first_lane;
    @(posedge clk_in) disable iff (!nrst_in)
    take_d && (widx == {7'h00, off[4:2]}) && (size != 11'h000)
      |=> data_valid_out && data_be_out[$past(off[1:0])];
  endproperty
  a_first_lane: assert property (p_first_lane) // [R10]
    else $error("first byte lane wrong");

  property p_first_seg;
    @(posedge clk_in) disable iff (!nrst_in)
    s_cmdb_first |=> sop_pend;
  endproperty
  a_first_seg: assert property (p_first_seg) // [R08]
    else $error("first segment not marked");

  property p_len_err;
    @(posedge clk_in) disable iff (!nrst_in)
    take_b && cmd_a[LS_BIT] && (next_total != {1'b0, word[LEN_HI:0]})
      |=> status[ST_ERR];
  endproperty
  a_len_err: assert property (p_len_err) // [R09]
    else $error("length mismatch did not set error");

  property p_offset_field;
    @(posedge clk_in) disable iff (!nrst_in)
    take_a |=> off == $past(word[OFF_HI:OFF_LO]);
  endproperty
  a_offset_field: assert property (p_offset_field) // [R11]
    else $error("start offset not taken from command A");
endmodule : txa_decoder

// ==== verilog/txa_pkg.sv ====
// Purpose: shared constants for the transmit command A decoder
// Assumes: one clock domain, 32-bit internal words, byte register map
// Notes: field positions refer to the first transmit command word, LEN_HI to the second
package txa_pkg;
  // command A field positions
  localparam int IOC_BIT = 31;
  localparam int ALIGN_HI = 25;
  localparam int ALIGN_LO = 24;
  localparam int OFF_HI = 20;
  localparam int OFF_LO = 16;
  localparam int FIRST_SEG_BIT = 13;
  localparam int LS_BIT = 12;
  localparam int SIZE_HI = 10;
  // command B packet length field
  localparam int LEN_HI = 10;

  // end alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSV = 2'h3;
  // alignment in words, minus one
  localparam logic [9:0] MASK_4 = 10'h000;
  localparam logic [9:0] MASK_16 = 10'h003;
  localparam logic [9:0] MASK_32 = 10'h007;

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_ENABLE = 8'h04;
  localparam logic [7:0] REG_CLEAR = 8'h08;
  localparam logic [7:0] REG_CMDA = 8'h0c;
  localparam logic [7:0] REG_TOTAL = 8'h10;

  // status, enable and clear layout
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 1;
  localparam int ST_W = 2;

  typedef enum logic [1:0] {
    TXA_CMDA,
    TXA_CMDB,
    TXA_DATA
  } txa_state_t;
endpackage : txa_pkg

// ==== verilog/txa_half_pair.sv ====
// Purpose: pairs 16-bit host writes into 32-bit words
// Assumes: writer is logic on the same clock, low half written first
// Notes: the word is presented one cycle after its upper half
`timescale 1ns/1ps
module txa_half_pair
  import txa_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic half_wr_in,
  input wire logic [15:0] half_in,
  output logic word_valid_out,
  output logic [31:0] word_out
);
  logic upper;
  logic [15:0] low_half;

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      upper <= 1'b0;
      low_half <= 16'h0000;
    end
    else if (half_wr_in)
    begin
      upper <= ~upper;
      if (!upper)
        low_half <= half_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      word_valid_out <= 1'b0;
      word_out <= 32'h0000_0000;
    end
    else
    begin
      word_valid_out <= half_wr_in && upper;
      if (half_wr_in && upper)
        word_out <= {half_in, low_half};
    end
  end
endmodule : txa_half_pair

// ==== test/txa_host_model.sv ====
// Purpose: host model writing command A, command B and buffer words
// Assumes: shares clk_in with the decoder, low half written first
// Notes: idle half bus shows the inverse of the last half, or the last half itself after a send with gap above 0
`timescale 1ns/1ps
module txa_host_model
  import txa_pkg::*;
(
  input wire logic clk_in,
  output logic half_wr_out,
  output logic [15:0] half_out
);
  initial half_wr_out = 1'b0;
  initial half_out = 16'h0000;

  // gap 0 keeps the strobe up for back to back halves
  task automatic put(input logic [15:0] v, input int gap);
    @(posedge clk_in);
    half_wr_out <= 1'b1;
    half_out <= v;
    if (gap > 0)
    begin
      @(posedge clk_in);
      half_wr_out <= 1'b0;
      half_out <= ~v;
      repeat (gap - 1) @(posedge clk_in);
    end
  endtask : put

  task automatic send(input logic ioc, input logic [1:0] al, input int off,
    input logic fseg, lseg, input int size, len, gap);
    int w;
    int m;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    w = (off + size + 3) / 4;
    m = (al == 2'h1) ? 4 : (al == 2'h2) ? 8 : 1;
    w = (w + m - 1) / m * m;
    a = {ioc, 5'h00, al, 3'h0, off[4:0], 2'h0, fseg, lseg, 1'b0,
      size[10:0]};
    b = {16'h0000, 5'h00, len[10:0]};
    put(a[15:0], gap);
    put(a[31:16], gap);
    put(b[15:0], gap);
    put(b[31:16], gap);
    for (int i = 0; i < w; i++)
    begin
      d = 32'h03020100 + i * 32'h04040404;
      put(d[15:0], gap);
      put(d[31:16], gap);
    end
    @(posedge clk_in);
    half_wr_out <= 1'b0;
    half_out <= ~half_out;
  endtask : send
endmodule : txa_host_model

// ==== test/testbench.sv ====
// Purpose: self-checking bench for the command A decoder
// Assumes: 25 MHz clock, host model on the half-word port
// Notes: every buffer outside t_seg is a whole packet, first and last segment
`timescale 1ns/1ps
module testbench
  import txa_pkg::*;
();
  logic clk_in;
  logic nrst_in = 1'b0;
  logic half_wr;
  logic [15:0] half;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata;
  logic dv;
  logic [31:0] dout;
  logic [3:0] be;
  logic first;
  logic last;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  int nv;
  logic [3:0] f_be;
  logic [31:0] f_dat;
  logic f_first;
  logic l_ls;

  txa_host_model host (.clk_in(clk_in), .half_wr_out(half_wr),
    .half_out(half));
  txa_decoder uut (.clk_in(clk_in), .nrst_in(nrst_in),
    .half_wr_in(half_wr), .half_in(half), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .data_valid_out(dv), .data_out(dout),
    .data_be_out(be), .data_first_out(first), .data_last_out(last),
    .irq_out(irq));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in)
    if (dv === 1'b1)
    begin
      if (nv == 0)
      begin
        f_be = be;
        f_dat = dout;
        f_first = first;
      end
      l_ls = last;
      nv++;
    end

  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // one buffer with completion request, checked at the ports
  task automatic buf_run(input logic [1:0] al, input int off, size, len,
    gap, input logic eerr);
    logic [31:0] d;
    nv = 0;
    host.send(1'b1, al, off, 1'b1, 1'b1, size, len, gap);
    repeat (4) @(posedge clk_in);
    chk("data words", (off + size + 3) / 4 - off / 4, nv);
    chk("first lanes", 4'(4'hf << (off % 4)), f_be);
    chk("first word", 32'h03020100 + off / 4 * 32'h04040404, f_dat);
    chk("first flag", 1'b1, f_first);
    chk("last flag", 1'b1, l_ls);
    chk("masked irq", 1'b0, irq);
    rd(REG_STATUS, d);
    chk("status", {30'h0, eerr, 1'b1}, d);
    rd(REG_TOTAL, d);
    chk("total", size, d);
    rd(REG_CMDA, d);
    chk("offset field", off, d[OFF_HI:OFF_LO]);
    wr(REG_CLEAR, 32'h3);
  endtask : buf_run

  task automatic t_lanes;
    for (int o = 0; o < 4; o++)
      buf_run(ALIGN_4, o, 4, 4, o, 1'b0);
    buf_run(ALIGN_4, 31, 1, 1, 1, 1'b0);
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_align;
    for (int a = 0; a < 3; a++)
      buf_run(a[1:0], 2, 9, 9, 0, 1'b0);
    $display("test align done");
  endtask : t_align

  task automatic t_err;
    buf_run(ALIGN_4, 0, 4, 5, 0, 1'b1);
    buf_run(ALIGN_RSV, 0, 4, 4, 0, 1'b1);
    $display("test error done");
  endtask : t_err

  // two segments summed into one packet, then a stray last segment
  task automatic t_seg;
    logic [31:0] d;
    nv = 0;
    host.send(1'b0, ALIGN_4, 1, 1'b1, 1'b0, 3, 8, 0);
    repeat (4) @(posedge clk_in);
    chk("seg1 first", 1'b1, f_first);
    chk("seg1 last", 1'b0, l_ls);
    nv = 0;
    host.send(1'b0, ALIGN_4, 0, 1'b0, 1'b1, 5, 8, 0);
    repeat (4) @(posedge clk_in);
    chk("seg2 first", 1'b0, f_first);
    chk("seg2 last", 1'b1, l_ls);
    chk("seg2 words", 32'h2, nv);
    rd(REG_TOTAL, d);
    chk("seg total", 32'h8, d);
    rd(REG_STATUS, d);
    chk("seg status", 32'h0, d);
    host.send(1'b0, ALIGN_4, 0, 1'b0, 1'b1, 4, 4, 0);
    repeat (4) @(posedge clk_in);
    rd(REG_STATUS, d);
    chk("stray seg", 32'h2, d);
    wr(REG_CLEAR, 32'h3);
    $display("test segments done");
  endtask : t_seg

  task automatic t_irq;
    logic [31:0] d;
    wr(REG_ENABLE, 32'h1);
    rd(REG_ENABLE, d);
    chk("enable", 32'h1, d);
    host.send(1'b1, ALIGN_16, 0, 1'b1, 1'b1, 4, 4, 0);
    repeat (4) @(posedge clk_in);
    #1 chk("irq set", 1'b1, irq);
    wr(REG_ENABLE, 32'h0);
    wr(REG_STATUS, 32'h0);
    repeat (2) @(posedge clk_in);
    #1 chk("irq off", 1'b0, irq);
    rd(REG_STATUS, d);
    chk("status ro", 32'h1, d);
    wr(REG_ENABLE, 32'h1);
    repeat (2) @(posedge clk_in);
    #1 chk("irq again", 1'b1, irq);
    wr(REG_CLEAR, 32'h1);
    repeat (2) @(posedge clk_in);
    #1 chk("irq clear", 1'b0, irq);
    rd(REG_CLEAR, d);
    chk("clear reads", 32'h0, d);
    rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    wr(REG_ENABLE, 32'h0);
    $display("test irq done");
  endtask : t_irq

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_lanes();
    t_align();
    t_err();
    t_seg();
    t_irq();
    summarize();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_in);
    errors++;
    summarize();
  end
endmodule : testbench
